/* dv/ssf_ctrl_properties.sv */
// Port assertions for the scan sample buffer
`timescale 1ns/1ps
`default_nettype none
module ssf_ctrl_properties #(
  parameter int unsigned DEPTH = 4096
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic scan_stop_cmd_in,
  input wire logic conv_enable_out,
  input wire logic sample_valid_in,
  input wire logic buffer_read_cmd_in,
  input wire logic [ssf_pkg::SSF_REQ_W-1:0] requested_word_count_in,
  input wire logic read_busy_out,
  input wire logic [ssf_pkg::SSF_REQ_W-1:0] delivered_word_count_out,
  input wire logic buffer_unlock_cmd_in,
  input wire logic buffer_clear_cmd_in,
  input wire logic buffer_locked_out,
  input wire logic [ssf_pkg::SSF_CNT_W-1:0] stored_word_count_out,
  input wire logic [ssf_pkg::SSF_THR_W-1:0] irq_threshold_code_in,
  input wire logic irq_status_clear_cmd_in,
  input wire logic irq_out
);
  import ssf_pkg::*;
  logic [SSF_CNT_W-1:0] thr;
  logic [SSF_CNT_W-1:0] cnt;
  logic [SSF_REQ_W-1:0] take;
  ////////////////////////////////////////
  // Live threshold in words, and the grant a read may earn
  always_comb begin
    cnt = stored_word_count_out;
    case (irq_threshold_code_in)
      3'h0: thr = SSF_THR_CNT0;
      3'h1: thr = SSF_THR_CNT1;
      3'h2: thr = SSF_THR_CNT2;
      3'h3: thr = SSF_THR_CNT3;
      3'h4: thr = SSF_THR_CNT4;
      3'h5: thr = SSF_THR_CNT5;
      3'h6: thr = SSF_THR_CNT6;
      default: thr = SSF_THR_CNT7;
    endcase
    take = (requested_word_count_in < {3'h0, cnt}) ? requested_word_count_in : {3'h0, cnt};
  end
  ////////////////////////////////////////
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  a_stop_halts: assert property (scan_stop_cmd_in |=> !conv_enable_out)
    else $error("scan ran on after stop");
  a_start_writes: assert property (conv_enable_out && sample_valid_in && !buffer_locked_out
    && !buffer_clear_cmd_in && !read_busy_out && !buffer_read_cmd_in |=> cnt == $past(cnt) + 13'h1)
    else $error("sample not stored");
  a_take_min: assert property (buffer_read_cmd_in && !read_busy_out |=>
    delivered_word_count_out == $past(take)) else $error("bad delivered count");
  a_lock_hold: assert property (buffer_locked_out && !buffer_unlock_cmd_in |=>
    buffer_locked_out) else $error("lock dropped");
  a_locked_drop: assert property (buffer_locked_out |=> cnt <= $past(cnt))
    else $error("word stored while locked");
  a_clear_empty: assert property (buffer_clear_cmd_in && !buffer_locked_out
    && !buffer_unlock_cmd_in && !read_busy_out && !buffer_read_cmd_in |=> cnt == 13'h0)
    else $error("clear left words");
  a_irq_over: assert property (cnt > thr && !buffer_clear_cmd_in |=> irq_out)
    else $error("interrupt missing");
  a_irq_sticky: assert property (irq_out && !irq_status_clear_cmd_in
    && !buffer_clear_cmd_in |=> irq_out) else $error("interrupt lost");
  // Main scenarios: a full buffer, a granted read, a raised interrupt
  c_full: cover property (cnt == SSF_CNT_W'(DEPTH));
  c_read: cover property (buffer_read_cmd_in && take != 16'h0);
  c_irq: cover property ($rose(irq_out));
endmodule // ssf_ctrl_properties
`default_nettype wire

/* dv/ssf_host_model.sv */
// Host side model that drains the output word stream
`timescale 1ns/1ps
`default_nettype none
module ssf_host_model (
  input wire logic clk_sys_in,
  input wire logic stall_in,
  input wire logic word_valid_in,
  input wire logic [15:0] word_data_in,
  output logic word_ready_out,
  output logic [15:0] got_count_out,
  output logic [15:0] last_word_out
);
  // One process drives each state bit; the ports only mirror it
  logic rdy = 1'b0;
  logic [15:0] got = 16'h0;
  logic [15:0] last = 16'h0;
  assign word_ready_out = rdy;
  assign got_count_out = got;
  assign last_word_out = last;
  // Slow mode takes every other cycle so the stream must wait
  always @(negedge clk_sys_in) begin
    rdy <= stall_in ? !rdy : 1'b1;
  end
  // Count each word taken and keep the last one, as the handler drains it
  always @(posedge clk_sys_in) begin
    if (word_valid_in && rdy) begin
      got <= got + 16'h1;
      last <= word_data_in;
    end
  end
endmodule // ssf_host_model
`default_nettype wire

/* dv/tb_ssf_ctrl.sv */
// Self-checking bench for the scan sample buffer
`timescale 1ns/1ps
`default_nettype none
module tb_ssf_ctrl;
  import ssf_pkg::*;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [4:0] cmd = 5'h0;
  logic svalid = 1'b0;
  logic rcmd = 1'b0;
  logic stall = 1'b0;
  logic [15:0] sdata = 16'h0;
  logic [15:0] req = 16'h0;
  logic [2:0] thr = 3'h0;
  logic [15:0] dcnt, wdata, got, lastw, exp_w;
  logic [15:0] seq = 16'hA000;
  logic [12:0] cnt;
  logic conv, busy, done, wvalid, wready, locked, irq;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  logic [15:0] q[$];
  // Command bits: start, stop, unlock, clear, interrupt clear
  ssf_ctrl ssf_ctrl_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .scan_start_cmd_in(cmd[0]), .scan_stop_cmd_in(cmd[1]), .conv_enable_out(conv),
    .sample_valid_in(svalid), .sample_data_in(sdata), .buffer_read_cmd_in(rcmd),
    .requested_word_count_in(req), .read_busy_out(busy), .read_done_out(done),
    .delivered_word_count_out(dcnt), .word_valid_out(wvalid), .word_ready_in(wready),
    .word_data_out(wdata), .buffer_unlock_cmd_in(cmd[2]), .buffer_clear_cmd_in(cmd[3]),
    .buffer_locked_out(locked), .stored_word_count_out(cnt), .irq_threshold_code_in(thr),
    .irq_status_clear_cmd_in(cmd[4]), .irq_out(irq));
  ssf_host_model ssf_host_model_inst (.clk_sys_in(clk_sys_in), .stall_in(stall),
    .word_valid_in(wvalid), .word_data_in(wdata), .word_ready_out(wready),
    .got_count_out(got), .last_word_out(lastw));
  ////////////////////////////////////////
  initial begin
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  // Watchdog well past the longest run of about 5,400 cycles
  initial begin
    #2500000;
    num_errors++;
    give_verdict();
  end
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One-cycle command pulse on bit b
  task automatic pulse(input int b);
    @(negedge clk_sys_in) cmd[b] = 1'b1;
    @(negedge clk_sys_in) cmd = 5'h0;
  endtask
  function automatic logic [2:0] sat(input int v);
    return (v > 7) ? 3'h7 : v[2:0];
  endfunction
  // Feed samples, mirroring those a running, unlocked, non-full buffer keeps
  task automatic put(input int k);
    repeat (k) begin
      @(negedge clk_sys_in);
      svalid = 1'b1;
      sdata = seq;
      if (conv && !locked && q.size() < SSF_DEPTH) q.push_back(seq);
      seq++;
    end
    @(negedge clk_sys_in) svalid = 1'b0;
    repeat (2) @(negedge clk_sys_in);
  endtask
  // Counted read: grant, words streamed and last word in order
  task automatic rd(input logic [15:0] r);
    logic [15:0] g0, m;
    int k;
    g0 = got;
    m = (r < q.size()) ? r : 16'(q.size());
    exp_w = lastw;
    repeat (m) exp_w = q.pop_front();
    @(negedge clk_sys_in);
    rcmd = 1'b1;
    req = r;
    @(negedge clk_sys_in) rcmd = 1'b0;
    chk({15'h0, busy}, {15'h0, m != 16'h0});
    for (k = 0; k < 20000 && done !== 1'b1; k++) @(negedge clk_sys_in);
    if (k == 20000) begin
      num_errors++;
      $display("MISMATCH t=%0t read never completed", $time);
    end
    chk({15'h0, busy}, 16'h0);
    chk(dcnt, m);
    chk(got - g0, m);
    chk(lastw, exp_w);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (4) @(negedge clk_sys_in);
    nrst_in = 1'b1;
    pulse(0);
    put(5);
    chk({3'h0, cnt}, 16'h5);
    rd(16'h3);
    rd(16'hA);
    rd(16'h4);
    // Interrupt survives a stalled drain until cleared
    put(9);
    chk({15'h0, irq}, 16'h1);
    stall = 1'b1;
    rd(16'h9);
    stall = 1'b0;
    chk({15'h0, irq}, 16'h1);
    pulse(4);
    chk({15'h0, irq}, 16'h0);
    // Per code: the level keeps the interrupt low, one word more raises it
    for (int i = 0; i < 8; i++) begin
      thr = sat((i == 7) ? 100 : i);
      n = (i == 7) ? 2048 : 8 << i;
      pulse(2);
      pulse(3);
      q.delete();
      chk({2'h0, irq, cnt}, 16'h0);
      put(n);
      chk({15'h0, irq}, 16'h0);
      put(1);
      chk({15'h0, irq}, 16'h1);
    end
    // Overfill: locks at full, drops extra samples, still serves reads
    put(2100);
    chk({3'h0, cnt}, 16'(SSF_DEPTH));
    rd(16'h4);
    chk({15'h0, locked}, 16'h1);
    pulse(3);
    chk({3'h0, cnt}, 16'(SSF_DEPTH - 4));
    pulse(2);
    chk({15'h0, locked}, 16'h0);
    pulse(3);
    q.delete();
    chk({3'h0, cnt}, 16'h0);
    pulse(1);
    put(3);
    chk({2'h0, conv, cnt}, 16'h0);
    give_verdict();
  end
endmodule // tb_ssf_ctrl
// Port checker attached to the buffer block
bind ssf_ctrl ssf_ctrl_properties #(.DEPTH(DEPTH)) ssf_ctrl_properties_inst (
  .clk_sys_in(clk_sys_in),
  .nrst_in(nrst_in),
  .scan_stop_cmd_in(scan_stop_cmd_in),
  .conv_enable_out(conv_enable_out),
  .sample_valid_in(sample_valid_in),
  .buffer_read_cmd_in(buffer_read_cmd_in),
  .requested_word_count_in(requested_word_count_in),
  .read_busy_out(read_busy_out),
  .delivered_word_count_out(delivered_word_count_out),
  .buffer_unlock_cmd_in(buffer_unlock_cmd_in),
  .buffer_clear_cmd_in(buffer_clear_cmd_in),
  .buffer_locked_out(buffer_locked_out),
  .stored_word_count_out(stored_word_count_out),
  .irq_threshold_code_in(irq_threshold_code_in),
  .irq_status_clear_cmd_in(irq_status_clear_cmd_in),
  .irq_out(irq_out)
);
`default_nettype wire

/* pkg/ssf_pkg.sv */
// Shared constants and types for the scan sample buffer
package ssf_pkg;
  localparam int unsigned SSF_SAMPLE_W = 16;
  localparam int unsigned SSF_DEPTH = 4096;
  localparam int unsigned SSF_PTR_W = 12;
  localparam int unsigned SSF_CNT_W = 13;
  localparam int unsigned SSF_REQ_W = 16;
  localparam int unsigned SSF_THR_W = 3;
  localparam int unsigned SSF_OUT_DEPTH = 4;
  localparam logic [SSF_THR_W-1:0] SSF_THR_RESET = 3'h0;
  // Threshold code to word count table
  localparam logic [SSF_CNT_W-1:0] SSF_THR_CNT0 = 13'h0008;
  localparam logic [SSF_CNT_W-1:0] SSF_THR_CNT1 = 13'h0010;
  localparam logic [SSF_CNT_W-1:0] SSF_THR_CNT2 = 13'h0020;
  localparam logic [SSF_CNT_W-1:0] SSF_THR_CNT3 = 13'h0040;
  localparam logic [SSF_CNT_W-1:0] SSF_THR_CNT4 = 13'h0080;
  localparam logic [SSF_CNT_W-1:0] SSF_THR_CNT5 = 13'h0100;
  localparam logic [SSF_CNT_W-1:0] SSF_THR_CNT6 = 13'h0200;
  localparam logic [SSF_CNT_W-1:0] SSF_THR_CNT7 = 13'h0800;
  // Read engine states
  typedef enum logic [1:0] {
    SSF_RD_IDLE = 2'b01,
    SSF_RD_MOVE = 2'b10
  } ssf_rd_state_t;
endpackage

/* rtl/ssf_ctrl.sv */
// Scan sample buffer: sample store, lock, clear, counted reads and threshold interrupt
// What this block does
// - A scan stop command halts conversion and no more words enter the buffer afterwards.
// - A read asking for more words than are stored delivers all stored words and completes once the host has taken the last of them.
// - Every read reports the number of words it actually delivered.
// - A full buffer locks and stays locked until the unlock command.
// - The clear command empties the buffer and acts as the step after unlock.
// - The interrupt rises while the stored count is strictly above the threshold word count.
// - Interrupt status holds until the host clears it after draining through reads.
// - The 3-bit threshold code maps 0 to 7 onto 8, 16, 32, 64, 128, 256, 512 and 2048 words.
// - Once started, each converted sample is written into the buffer immediately, except while locked or in a cycle where a clear is honoured.
`timescale 1ns/1ps
`default_nettype none
module ssf_ctrl #(
  parameter int unsigned DEPTH = ssf_pkg::SSF_DEPTH,
  parameter int unsigned OUT_DEPTH = ssf_pkg::SSF_OUT_DEPTH
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic scan_start_cmd_in,
  input wire logic scan_stop_cmd_in,
  output logic conv_enable_out,
  input wire logic sample_valid_in,
  input wire logic [ssf_pkg::SSF_SAMPLE_W-1:0] sample_data_in,
  input wire logic buffer_read_cmd_in,
  input wire logic [ssf_pkg::SSF_REQ_W-1:0] requested_word_count_in,
  output logic read_busy_out,
  output logic read_done_out,
  output logic [ssf_pkg::SSF_REQ_W-1:0] delivered_word_count_out,
  output logic word_valid_out,
  input wire logic word_ready_in,
  output logic [ssf_pkg::SSF_SAMPLE_W-1:0] word_data_out,
  input wire logic buffer_unlock_cmd_in,
  input wire logic buffer_clear_cmd_in,
  output logic buffer_locked_out,
  output logic [ssf_pkg::SSF_CNT_W-1:0] stored_word_count_out,
  input wire logic [ssf_pkg::SSF_THR_W-1:0] irq_threshold_code_in,
  input wire logic irq_status_clear_cmd_in,
  output logic irq_out
);
  import ssf_pkg::*;

  // Word count selected by a threshold code
  function automatic logic [SSF_CNT_W-1:0] thr_words(input logic [SSF_THR_W-1:0] code);
    logic [SSF_CNT_W-1:0] w;
    w = SSF_THR_CNT0;
    unique case (code)
      3'h0: w = SSF_THR_CNT0;
      3'h1: w = SSF_THR_CNT1;
      3'h2: w = SSF_THR_CNT2;
      3'h3: w = SSF_THR_CNT3;
      3'h4: w = SSF_THR_CNT4;
      3'h5: w = SSF_THR_CNT5;
      3'h6: w = SSF_THR_CNT6;
      3'h7: w = SSF_THR_CNT7;
    endcase
    return w;
  endfunction

  // Pointer advance with wrap at the memory depth
  function automatic logic [SSF_PTR_W-1:0] ptr_inc(input logic [SSF_PTR_W-1:0] p);
    return (p == SSF_PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [SSF_SAMPLE_W-1:0] mem [DEPTH];
  logic scanning;
  logic locked;
  logic irq_pending;
  logic [SSF_PTR_W-1:0] wr_ptr;
  logic [SSF_PTR_W-1:0] rd_ptr;
  logic [SSF_CNT_W-1:0] count;
  ssf_rd_state_t rd_state;
  logic [SSF_REQ_W-1:0] remain;
  logic [SSF_REQ_W-1:0] delivered;
  logic done;
  logic next_scanning;
  logic next_locked;
  logic next_irq_pending;
  logic [SSF_PTR_W-1:0] next_wr_ptr;
  logic [SSF_PTR_W-1:0] next_rd_ptr;
  logic [SSF_CNT_W-1:0] next_count;
  ssf_rd_state_t next_rd_state;
  logic [SSF_REQ_W-1:0] next_remain;
  logic [SSF_REQ_W-1:0] next_delivered;
  logic next_done;
  logic wr_en;
  logic mv_en;
  logic do_clear;
  logic stage_ready;
  logic stage_valid;
  logic full;
  logic [SSF_REQ_W-1:0] take;

  ////////////////////////////////////////////////////////////////////////////
  // Datapath strobes
  assign full = (count == SSF_CNT_W'(DEPTH));
  // Clear is only honoured once unlocked and with no read in flight,
  // so a clear can never tear words out from under an active transfer
  assign do_clear = buffer_clear_cmd_in && !locked && (rd_state == SSF_RD_IDLE);
  // Samples go straight in while scanning; locked or stopped drops them
  assign wr_en = sample_valid_in && scanning && !locked && !full && !do_clear;
  assign mv_en = (rd_state == SSF_RD_MOVE) && (remain != '0) && stage_ready && (count != '0);
  // Words granted: the request, trimmed to what is stored right now
  assign take = ({3'h0, count} < requested_word_count_in) ? {3'h0, count}
                : requested_word_count_in;

  // Scan run state; stop wins over a simultaneous start
  always_comb begin
    next_scanning = scanning;
    if (scan_stop_cmd_in) begin
      next_scanning = 1'b0;
    end else if (scan_start_cmd_in) begin
      next_scanning = 1'b1;
    end
  end

  // Buffer pointers, count, lock and interrupt status
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    next_locked = locked;
    next_irq_pending = irq_pending;
    if (do_clear) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count = '0;
      next_irq_pending = 1'b0;
    end else begin
      if (wr_en) begin
        next_wr_ptr = ptr_inc(wr_ptr);
      end
      if (mv_en) begin
        next_rd_ptr = ptr_inc(rd_ptr);
      end
      if (wr_en && !mv_en) begin
        next_count = count + 1'b1;
      end else if (mv_en && !wr_en) begin
        next_count = count - 1'b1;
      end
      // Status is sticky; a new crossing in the clear cycle wins
      if (irq_status_clear_cmd_in) begin
        next_irq_pending = 1'b0;
      end
      if (count > thr_words(irq_threshold_code_in)) begin
        next_irq_pending = 1'b1;
      end
    end
    // Lock on reaching full; only the unlock command releases it
    if (buffer_unlock_cmd_in) begin
      next_locked = 1'b0;
    end
    if (next_count == SSF_CNT_W'(DEPTH)) begin
      next_locked = 1'b1;
    end
  end

  // Read engine: grant, move words to the staging FIFO, report the total
  always_comb begin
    next_rd_state = rd_state;
    next_remain = remain;
    next_delivered = delivered;
    next_done = 1'b0;
    unique case (rd_state)
      SSF_RD_IDLE: begin
        if (buffer_read_cmd_in) begin
          next_delivered = take;
          next_remain = take;
          if (take == '0) begin
            next_done = 1'b1;
          end else begin
            next_rd_state = SSF_RD_MOVE;
          end
        end
      end
      SSF_RD_MOVE: begin
        if (mv_en) begin
          next_remain = remain - 1'b1;
        end
        // Finish only once the host has taken the last staged word
        if ((remain == '0) && !stage_valid) begin
          next_done = 1'b1;
          next_rd_state = SSF_RD_IDLE;
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scanning <= 1'b0;
      locked <= 1'b0;
      irq_pending <= 1'b0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      rd_state <= SSF_RD_IDLE;
      remain <= '0;
      delivered <= '0;
      done <= 1'b0;
    end else begin
      scanning <= next_scanning;
      locked <= next_locked;
      irq_pending <= next_irq_pending;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      rd_state <= next_rd_state;
      remain <= next_remain;
      delivered <= next_delivered;
      done <= next_done;
    end
  end

  // Sample memory; no reset, since only counted words are ever read
  always_ff @(posedge clk_sys_in) begin
    if (wr_en) begin
      mem[wr_ptr] <= sample_data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Staging FIFO lets the host stall without holding up sample capture
  ssf_out_fifo #(
    .WIDTH(SSF_SAMPLE_W),
    .DEPTH(OUT_DEPTH)
  ) u_stage (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .flush_in(do_clear),
    .in_valid_in(mv_en),
    .in_ready_out(stage_ready),
    .in_data_in(mem[rd_ptr]),
    .out_valid_out(stage_valid),
    .out_ready_in(word_ready_in),
    .out_data_out(word_data_out)
  );

  // Outputs
  assign word_valid_out = stage_valid;
  assign conv_enable_out = scanning;
  assign buffer_locked_out = locked;
  assign stored_word_count_out = count;
  assign irq_out = irq_pending;
  assign read_busy_out = (rd_state == SSF_RD_MOVE);
  assign read_done_out = done;
  assign delivered_word_count_out = delivered;
endmodule // ssf_ctrl
`default_nettype wire

/* rtl/ssf_out_fifo.sv */
// Small output staging FIFO between the sample memory and the host port
`timescale 1ns/1ps
`default_nettype none
module ssf_out_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] fill;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_fill;
  logic push;
  logic pop;

  ////////////////////////////////////////////////////////////////////////////
  // Handshakes; full and empty come straight from the fill level
  assign in_ready_out = (fill < (AW+1)'(DEPTH)); // Full only at DEPTH words
  assign out_valid_out = (fill != '0);
  assign out_data_out = mem[rd_ptr];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Pointer wrap uses the depth, so non power of two depths also work
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_fill = fill;
    if (flush_in) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_fill = '0;
    end else begin
      if (push) begin
        next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        next_fill = fill + 1'b1;
      end else if (pop && !push) begin
        next_fill = fill - 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill <= next_fill;
    end
  end

  // Storage has no reset; contents are only read while counted valid
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end
endmodule // ssf_out_fifo
`default_nettype wire
